// *** cpud_defs.svh ***
// constants for the opcode decoder and bus cycle sequencer
// How it works
// - opcode 94: two cycles, free then fetch, stack pointer = index pair - 1
// - wait: free then fetch, clears interrupt mask, then stops executing
// - a free cycle is one bus clock and shows as a read
// - fetch reads next program byte; operand read/write moves one byte
// - push writes one stack byte; each push is a bus cycle
// - vectors come from the top page, high byte first
// - relative offsets are signed bytes from the next instruction
// - direct mode address is zero high byte and operand low byte
// - 8-bit index offsets are unsigned, added to the index pair
// - bit instructions take bit number 0 to 2 from the opcode
// - 00 branch if bit 0 set, 10 set bit 0, both five cycles
// - 05 branch if bit 2 clear, 15 clear bit 2, five cycles
// - 20 branch always three cycles; 30 negate direct five cycles
// - 31 compare-branch direct five cycles; 41 accumulator form four cycles
// - 35 store index pair four cycles; 45 load index pair three cycles
`ifndef CPUD_DEFS_SVH
`define CPUD_DEFS_SVH

`define CPUD_VEC_RST         16'hfffe
`define CPUD_VEC_IRQ         16'hfff8
`define CPUD_STACK_PTR_RST   16'h00ff
`define CPUD_FLAGS_RST       8'h68

`define CPUD_FLG_C           0
`define CPUD_FLG_Z           1
`define CPUD_FLG_N           2
`define CPUD_FLG_I           3
`define CPUD_FLG_V           7

`define CPUD_OP_XFER         8'h94
`define CPUD_OP_WAIT         8'h8f
`define CPUD_OP_NEGATE       8'h30
`define CPUD_OP_CMP_DIR      8'h31
`define CPUD_OP_CMP_IDX      8'h61
`define CPUD_OP_ACC_CMP      8'h41
`define CPUD_OP_STORE_DIR    8'h35
`define CPUD_OP_LOAD_LIT     8'h45
`define CPUD_OP_LOAD_DIR     8'h55
`define CPUD_OP_BITMAN_LAST  4'h5
`define CPUD_OP_REL_FIRST    8'h20
`define CPUD_OP_REL_LAST     8'h25

`define CPUD_CYC_XFER        4'd2
`define CPUD_CYC_WAIT        4'd2
`define CPUD_CYC_BITMAN      4'd5
`define CPUD_CYC_REL         4'd3
`define CPUD_CYC_NEGATE      4'd5
`define CPUD_CYC_CMP         4'd5
`define CPUD_CYC_ACC_CMP     4'd4
`define CPUD_CYC_STORE       4'd4
`define CPUD_CYC_LOAD_LIT    4'd3
`define CPUD_CYC_LOAD_DIR    4'd4

`endif

// *** cpud_pkg.sv ***
// types shared by the opcode decoder and the cycle sequencer
package cpud_pkg;
  typedef enum logic [3:0] {
    k_rst     = 4'b0000,
    k_irq     = 4'b0001,
    k_xfer    = 4'b0010,
    k_wait    = 4'b0011,
    k_brbit   = 4'b0100,
    k_bitwr   = 4'b0101,
    k_brrel   = 4'b0110,
    k_negate  = 4'b0111,
    k_cmpeq   = 4'b1000,
    k_acmp    = 4'b1001,
    k_store   = 4'b1010,
    k_ldlit   = 4'b1011,
    k_lddir   = 4'b1100,
    k_illegal = 4'b1101
  } cpud_cls_t;
  // f free, p operand fetch, r read, w write, s push, v vector, n opcode fetch, d wait fetch
  typedef enum logic [2:0] {
    cyc_f = 3'b000,
    cyc_p = 3'b001,
    cyc_r = 3'b010,
    cyc_w = 3'b011,
    cyc_s = 3'b100,
    cyc_v = 3'b101,
    cyc_n = 3'b110,
    cyc_d = 3'b111
  } cpud_code_t;
  typedef enum logic [1:0] {
    st_run  = 2'b00,
    st_halt = 2'b01,
    st_dead = 2'b10
  } cpud_st_t;
endpackage : cpud_pkg

// *** cpud_decode.sv ***
// opcode decoder: instruction class, bit number and cycle count
`timescale 1ns/1ps
`include "cpud_defs.svh"
module cpud_decode (
  input  logic [7:0]          opcode,   // byte from the opcode fetch
  output cpud_pkg::cpud_cls_t cls,      // instruction class
  output logic [2:0]          bit_num,  // bit selected by bit instructions
  output logic [3:0]          cycles,   // documented cycle count
  output logic                legal     // opcode is in the decode map
);
  always_comb begin
    cls     = cpud_pkg::k_illegal;
    cycles  = 4'd0;
    legal   = 1'b1;
    bit_num = opcode[3:1];
    if (opcode[7:4] == 4'h0 && opcode[3:0] <= `CPUD_OP_BITMAN_LAST) begin
      cls    = cpud_pkg::k_brbit;
      cycles = `CPUD_CYC_BITMAN;
    end else if (opcode[7:4] == 4'h1 && opcode[3:0] <= `CPUD_OP_BITMAN_LAST) begin
      cls    = cpud_pkg::k_bitwr;
      cycles = `CPUD_CYC_BITMAN;
    end else if (opcode >= `CPUD_OP_REL_FIRST && opcode <= `CPUD_OP_REL_LAST) begin
      cls    = cpud_pkg::k_brrel;
      cycles = `CPUD_CYC_REL;
    end else begin
      case (opcode)
        `CPUD_OP_NEGATE: begin
          cls    = cpud_pkg::k_negate;
          cycles = `CPUD_CYC_NEGATE;
        end
        `CPUD_OP_CMP_DIR, `CPUD_OP_CMP_IDX: begin
          cls    = cpud_pkg::k_cmpeq;
          cycles = `CPUD_CYC_CMP;
        end
        `CPUD_OP_ACC_CMP: begin
          cls    = cpud_pkg::k_acmp;
          cycles = `CPUD_CYC_ACC_CMP;
        end
        `CPUD_OP_STORE_DIR: begin
          cls    = cpud_pkg::k_store;
          cycles = `CPUD_CYC_STORE;
        end
        `CPUD_OP_LOAD_LIT: begin
          cls    = cpud_pkg::k_ldlit;
          cycles = `CPUD_CYC_LOAD_LIT;
        end
        `CPUD_OP_LOAD_DIR: begin
          cls    = cpud_pkg::k_lddir;
          cycles = `CPUD_CYC_LOAD_DIR;
        end
        `CPUD_OP_XFER: begin
          cls    = cpud_pkg::k_xfer;
          cycles = `CPUD_CYC_XFER;
        end
        `CPUD_OP_WAIT: begin
          cls    = cpud_pkg::k_wait;
          cycles = `CPUD_CYC_WAIT;
        end
        default: legal = 1'b0;
      endcase
    end
  end
endmodule : cpud_decode

// *** cpud_seq.sv ***
// bus cycle sequencer: cycle codes, operand capture and instruction effects
`timescale 1ns/1ps
`include "cpud_defs.svh"
module cpud_seq #(
  parameter int unsigned ADDR_W = 16   // address width
) (
  input  logic                 clk_sys,       // bus clock, 40 MHz
  input  logic                 rstn,          // synchronous reset, active low
  input  logic [7:0]           bus_rdata,     // read data of the current cycle
  input  logic                 irq_req,       // interrupt pending, level
  output logic [ADDR_W-1:0]    bus_addr_reg,  // bus address
  output logic                 bus_rd_reg,    // read cycle
  output logic                 bus_wr_reg,    // write cycle
  output logic [7:0]           bus_wdata_reg, // write data
  output cpud_pkg::cpud_code_t cyc_code_reg,  // code of the current cycle
  output logic                 halted_reg,    // stopped by wait
  output logic                 illegal_reg    // illegal opcode, to reset logic
);
  if (ADDR_W != 16) begin : g_chk
    $error("cpud_seq serves a 16-bit address only");
  end

  cpud_pkg::cpud_cls_t  cls_reg, cls_next, dec_cls;
  cpud_pkg::cpud_st_t   st_reg, st_next;
  cpud_pkg::cpud_code_t code_cur;
  logic [2:0]  step_reg, step_next, bit_reg, bit_next, dec_bit;
  logic [3:0]  cyc_reg, cyc_next, dec_cyc;
  logic        dec_legal;
  logic [7:0]  ir_reg, ir_next, opnd_reg, opnd_next;
  logic [7:0]  rel_reg, rel_next, mem_reg, mem_next;
  logic [7:0]  h_reg, h_next, x_reg, x_next;
  logic [7:0]  acc_reg, flags_reg, flags_next;
  logic [15:0] pc_reg, pc_next, sp_reg, sp_next, ea_reg, ea_next;
  logic [15:0] addr_next, hx_w, rel_sx;
  logic [7:0]  wdata_next, bit_mask, minus_mem;
  logic        rd_next, wr_next, halted_next, illegal_next, taken, cond;
  cpud_pkg::cpud_code_t code_next;

  assign hx_w     = {h_reg, x_reg};
  assign rel_sx   = {{8{rel_reg[7]}}, rel_reg};
  assign bit_mask = 8'h01 << bit_reg;
  assign acc_reg  = 8'h00;

  cpud_decode u_dec (
    .opcode  (bus_rdata),
    .cls     (dec_cls),
    .bit_num (dec_bit),
    .cycles  (dec_cyc),
    .legal   (dec_legal)
  );

  function automatic logic [15:0] ea_index(input logic [15:0] hx, input logic [15:0] off);
    ea_index = hx + off;
  endfunction : ea_index

  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [15:0] off);
    rel_target = pc + off;
  endfunction : rel_target

  function automatic logic [7:0] hx_flags(input logic [7:0] f, input logic [15:0] v);
    hx_flags = f;
    hx_flags[`CPUD_FLG_V] = 1'b0;
    hx_flags[`CPUD_FLG_N] = v[15];
    hx_flags[`CPUD_FLG_Z] = (v == 16'h0000);
  endfunction : hx_flags

  // cycle code of each step of each class; the last step fetches the next opcode
  function automatic cpud_pkg::cpud_code_t code_of(input cpud_pkg::cpud_cls_t c,
                                                   input logic [2:0] s);
    code_of = cpud_pkg::cyc_f;
    case (c)
      cpud_pkg::k_rst:
        code_of = (s == 3'd2) ? cpud_pkg::cyc_n : cpud_pkg::cyc_v;
      cpud_pkg::k_irq:
        if (s == 3'd7) code_of = cpud_pkg::cyc_n;
        else if (s >= 3'd5) code_of = cpud_pkg::cyc_v;
        else code_of = cpud_pkg::cyc_s;
      cpud_pkg::k_xfer:
        code_of = (s == 3'd0) ? cpud_pkg::cyc_f : cpud_pkg::cyc_n;
      cpud_pkg::k_wait:
        code_of = (s == 3'd0) ? cpud_pkg::cyc_f : cpud_pkg::cyc_d;
      cpud_pkg::k_brbit, cpud_pkg::k_cmpeq:
        case (s)
          3'd0:    code_of = cpud_pkg::cyc_p;
          3'd1:    code_of = cpud_pkg::cyc_r;
          3'd2:    code_of = cpud_pkg::cyc_p;
          3'd3:    code_of = cpud_pkg::cyc_f;
          default: code_of = cpud_pkg::cyc_n;
        endcase
      cpud_pkg::k_bitwr, cpud_pkg::k_negate:
        case (s)
          3'd0:    code_of = cpud_pkg::cyc_p;
          3'd1:    code_of = cpud_pkg::cyc_r;
          3'd2:    code_of = cpud_pkg::cyc_f;
          3'd3:    code_of = cpud_pkg::cyc_w;
          default: code_of = cpud_pkg::cyc_n;
        endcase
      cpud_pkg::k_brrel:
        case (s)
          3'd0:    code_of = cpud_pkg::cyc_p;
          3'd1:    code_of = cpud_pkg::cyc_f;
          default: code_of = cpud_pkg::cyc_n;
        endcase
      cpud_pkg::k_acmp:
        case (s)
          3'd0, 3'd1: code_of = cpud_pkg::cyc_p;
          3'd2:       code_of = cpud_pkg::cyc_f;
          default:    code_of = cpud_pkg::cyc_n;
        endcase
      cpud_pkg::k_store:
        case (s)
          3'd0:       code_of = cpud_pkg::cyc_p;
          3'd1, 3'd2: code_of = cpud_pkg::cyc_w;
          default:    code_of = cpud_pkg::cyc_n;
        endcase
      cpud_pkg::k_ldlit:
        code_of = (s <= 3'd1) ? cpud_pkg::cyc_p : cpud_pkg::cyc_n;
      cpud_pkg::k_lddir:
        case (s)
          3'd0:       code_of = cpud_pkg::cyc_p;
          3'd1, 3'd2: code_of = cpud_pkg::cyc_r;
          default:    code_of = cpud_pkg::cyc_n;
        endcase
      default: code_of = cpud_pkg::cyc_f;
    endcase
  endfunction : code_of

  always_comb begin
    cls_next     = cls_reg;
    st_next      = st_reg;
    step_next    = step_reg + 3'd1;
    bit_next     = bit_reg;
    cyc_next     = cyc_reg;
    ir_next      = ir_reg;
    opnd_next    = opnd_reg;
    rel_next     = rel_reg;
    mem_next     = mem_reg;
    h_next       = h_reg;
    x_next       = x_reg;
    flags_next   = flags_reg;
    pc_next      = pc_reg;
    sp_next      = sp_reg;
    ea_next      = ea_reg;
    halted_next  = halted_reg;
    illegal_next = illegal_reg;
    minus_mem    = 8'h00 - mem_reg;
    cond         = 1'b0;
    taken        = 1'b0;
    code_cur     = code_of(cls_reg, step_reg);
    // consume the cycle that is on the bus now
    if (st_reg == cpud_pkg::st_halt) begin
      step_next = step_reg;
      if (irq_req) begin
        st_next     = cpud_pkg::st_run;
        cls_next    = cpud_pkg::k_irq;
        step_next   = 3'd0;
        halted_next = 1'b0;
      end
    end else if (st_reg == cpud_pkg::st_dead) begin
      step_next = step_reg;
    end else begin
      case (code_cur)
        cpud_pkg::cyc_p: begin
          pc_next = pc_reg + 16'd1;
          if (step_reg == 3'd0) begin
            opnd_next = bus_rdata;
            // a plain branch carries its offset as the first operand byte
            if (cls_reg == cpud_pkg::k_brrel) rel_next = bus_rdata;
            if (cls_reg == cpud_pkg::k_cmpeq && ir_reg[6])
              ea_next = ea_index(hx_w, {8'h00, bus_rdata});
            else
              ea_next = {8'h00, bus_rdata};
          end else begin
            rel_next = bus_rdata;
          end
        end
        cpud_pkg::cyc_r: begin
          mem_next = bus_rdata;
          if (cls_reg == cpud_pkg::k_lddir) begin
            ea_next = ea_reg + 16'd1;
            if (step_reg == 3'd1) h_next = bus_rdata;
            else x_next = bus_rdata;
          end
        end
        cpud_pkg::cyc_w:
          if (cls_reg == cpud_pkg::k_store) ea_next = ea_reg + 16'd1;
        cpud_pkg::cyc_s:
          sp_next = sp_reg - 16'd1;
        cpud_pkg::cyc_v: begin
          flags_next[`CPUD_FLG_I] = 1'b1;
          if (step_reg[0] == (cls_reg == cpud_pkg::k_irq)) pc_next[15:8] = bus_rdata;
          else pc_next[7:0] = bus_rdata;
        end
        cpud_pkg::cyc_d: begin
          st_next     = cpud_pkg::st_halt;
          halted_next = 1'b1;
        end
        cpud_pkg::cyc_n: begin
          step_next = 3'd0;
          // pc stays on the opcode so that the stacked return address repeats it
          if (irq_req && !flags_reg[`CPUD_FLG_I]) begin
            cls_next = cpud_pkg::k_irq;
          end else if (!dec_legal) begin
            st_next      = cpud_pkg::st_dead;
            illegal_next = 1'b1;
          end else begin
            ir_next  = bus_rdata;
            cls_next = dec_cls;
            bit_next = dec_bit;
            cyc_next = dec_cyc;
            pc_next  = pc_reg + 16'd1;
          end
        end
        default:
          if (cls_reg == cpud_pkg::k_wait) flags_next[`CPUD_FLG_I] = 1'b0;
      endcase
      // effects land just before the final fetch, whose address may depend on them
      if (code_cur != cpud_pkg::cyc_n && code_of(cls_reg, step_next) == cpud_pkg::cyc_n) begin
        case (cls_reg)
          cpud_pkg::k_xfer:
            sp_next = hx_w - 16'd1;
          cpud_pkg::k_brbit: begin
            flags_next[`CPUD_FLG_C] = mem_reg[bit_reg];
            taken = (mem_reg[bit_reg] != ir_reg[0]);
          end
          cpud_pkg::k_brrel: begin
            case (ir_reg[2:1])
              2'b00:   cond = 1'b1;
              2'b01:   cond = !(flags_reg[`CPUD_FLG_C] || flags_reg[`CPUD_FLG_Z]);
              default: cond = !flags_reg[`CPUD_FLG_C];
            endcase
            taken = cond ^ ir_reg[0];
          end
          cpud_pkg::k_negate: begin
            flags_next[`CPUD_FLG_V] = (minus_mem == 8'h80);
            flags_next[`CPUD_FLG_N] = minus_mem[7];
            flags_next[`CPUD_FLG_Z] = (minus_mem == 8'h00);
            flags_next[`CPUD_FLG_C] = (minus_mem != 8'h00);
          end
          cpud_pkg::k_cmpeq: begin
            taken = (acc_reg == mem_reg);
            if (ir_reg[6]) {h_next, x_next} = hx_w + 16'd1;
          end
          cpud_pkg::k_acmp:
            taken = (acc_reg == opnd_reg);
          cpud_pkg::k_store:
            flags_next = hx_flags(flags_reg, hx_w);
          cpud_pkg::k_ldlit: begin
            h_next     = opnd_reg;
            // the low byte is on the bus in this very cycle, not yet registered
            x_next     = rel_next;
            flags_next = hx_flags(flags_reg, {opnd_reg, rel_next});
          end
          cpud_pkg::k_lddir:
            flags_next = hx_flags(flags_reg, {h_next, x_next});
          default: taken = 1'b0;
        endcase
        if (taken) pc_next = rel_target(pc_reg, rel_sx);
      end
    end
    // issue the next cycle
    code_next  = code_of(cls_next, step_next);
    rd_next    = 1'b0;
    wr_next    = 1'b0;
    addr_next  = pc_next;
    wdata_next = 8'h00;
    if (st_next == cpud_pkg::st_run) begin
      case (code_next)
        cpud_pkg::cyc_r: begin
          rd_next   = 1'b1;
          addr_next = ea_next;
        end
        cpud_pkg::cyc_w: begin
          wr_next   = 1'b1;
          addr_next = ea_next;
          if (cls_next == cpud_pkg::k_store) wdata_next = (step_next == 3'd1) ? h_next : x_next;
          else if (cls_next == cpud_pkg::k_negate) wdata_next = 8'h00 - mem_next;
          else if (ir_reg[0]) wdata_next = mem_next & ~bit_mask;
          else wdata_next = mem_next | bit_mask;
        end
        cpud_pkg::cyc_s: begin
          wr_next   = 1'b1;
          addr_next = sp_next;
          case (step_next)
            3'd0:    wdata_next = pc_next[7:0];
            3'd1:    wdata_next = pc_next[15:8];
            3'd2:    wdata_next = x_next;
            3'd3:    wdata_next = acc_reg;
            default: wdata_next = flags_next;
          endcase
        end
        cpud_pkg::cyc_v: begin
          rd_next = 1'b1;
          addr_next = ((cls_next == cpud_pkg::k_irq) ? `CPUD_VEC_IRQ : `CPUD_VEC_RST)
                    + {15'h0000, step_next[0] ^ (cls_next == cpud_pkg::k_irq)};
        end
        default:
          rd_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cls_reg       <= cpud_pkg::k_rst;
      st_reg        <= cpud_pkg::st_run;
      step_reg      <= 3'd0;
      bit_reg       <= 3'd0;
      cyc_reg       <= 4'd0;
      ir_reg        <= 8'h00;
      opnd_reg      <= 8'h00;
      rel_reg       <= 8'h00;
      mem_reg       <= 8'h00;
      h_reg         <= 8'h00;
      x_reg         <= 8'h00;
      flags_reg     <= `CPUD_FLAGS_RST;
      pc_reg        <= 16'h0000;
      sp_reg        <= `CPUD_STACK_PTR_RST;
      ea_reg        <= 16'h0000;
      bus_addr_reg  <= `CPUD_VEC_RST;
      bus_rd_reg    <= 1'b1;
      bus_wr_reg    <= 1'b0;
      bus_wdata_reg <= 8'h00;
      cyc_code_reg  <= cpud_pkg::cyc_v;
      halted_reg    <= 1'b0;
      illegal_reg   <= 1'b0;
    end else begin
      cls_reg       <= cls_next;
      st_reg        <= st_next;
      step_reg      <= step_next;
      bit_reg       <= bit_next;
      cyc_reg       <= cyc_next;
      ir_reg        <= ir_next;
      opnd_reg      <= opnd_next;
      rel_reg       <= rel_next;
      mem_reg       <= mem_next;
      h_reg         <= h_next;
      x_reg         <= x_next;
      flags_reg     <= flags_next;
      pc_reg        <= pc_next;
      sp_reg        <= sp_next;
      ea_reg        <= ea_next;
      bus_addr_reg  <= addr_next;
      bus_rd_reg    <= rd_next;
      bus_wr_reg    <= wr_next;
      bus_wdata_reg <= wdata_next;
      cyc_code_reg  <= code_next;
      halted_reg    <= halted_next;
      illegal_reg   <= illegal_next;
    end
  end

  // cycles since the last opcode fetch, read only by the checks below
  logic [3:0] a_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) a_cnt_reg <= 4'd0;
    else if (cyc_code_reg == cpud_pkg::cyc_n) a_cnt_reg <= 4'd1;
    else if (a_cnt_reg != 4'hf) a_cnt_reg <= a_cnt_reg + 4'd1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic run_w;
  assign run_w = (st_reg == cpud_pkg::st_run);

  xfer_stack_a: assert property (
    run_w && cls_reg == cpud_pkg::k_xfer && step_reg == 3'd0
    |=> sp_reg == $past(hx_w) - 16'd1 && cyc_code_reg == cpud_pkg::cyc_n)
    else $error("stack pointer not index pair minus one");
  wait_halt_a: assert property (
    run_w && cls_reg == cpud_pkg::k_wait && step_reg == 3'd1
    |=> halted_reg && !flags_reg[`CPUD_FLG_I])
    else $error("wait did not halt with mask clear");
  free_read_a: assert property (
    run_w && cyc_code_reg == cpud_pkg::cyc_f |-> bus_rd_reg && !bus_wr_reg)
    else $error("free cycle is not a read");
  fetch_next_a: assert property (
    run_w && cyc_code_reg == cpud_pkg::cyc_p |-> bus_rd_reg && bus_addr_reg == pc_reg
    ##1 pc_reg == $past(pc_reg) + 16'd1)
    else $error("fetch not from next program byte");
  push_stack_a: assert property (
    run_w && cyc_code_reg == cpud_pkg::cyc_s |-> bus_wr_reg && bus_addr_reg == sp_reg
    ##1 sp_reg == $past(sp_reg) - 16'd1)
    else $error("push not at stack pointer");
  vec_order_a: assert property (
    run_w && cls_reg == cpud_pkg::k_irq && step_reg == 3'd5
    |-> bus_addr_reg == `CPUD_VEC_IRQ ##1 bus_addr_reg == `CPUD_VEC_IRQ + 16'd1)
    else $error("vector bytes out of order");
  rel_branch_a: assert property (
    run_w && cls_reg == cpud_pkg::k_brrel && ir_reg == `CPUD_OP_REL_FIRST && step_reg == 3'd1
    |=> bus_addr_reg == $past(pc_reg) + $past(rel_sx))
    else $error("relative target wrong");
  direct_ea_a: assert property (
    run_w && cyc_code_reg == cpud_pkg::cyc_r && cls_reg != cpud_pkg::k_cmpeq
    && step_reg == 3'd1 |-> bus_addr_reg[15:8] == 8'h00)
    else $error("direct address off page zero");
  index_ea_a: assert property (
    run_w && cls_reg == cpud_pkg::k_cmpeq && ir_reg[6] && step_reg == 3'd1
    |-> bus_addr_reg == hx_w + {8'h00, opnd_reg})
    else $error("indexed offset not unsigned");
  bit_write_a: assert property (
    run_w && cls_reg == cpud_pkg::k_bitwr && cyc_code_reg == cpud_pkg::cyc_w
    |-> bus_wdata_reg == (ir_reg[0] ? (mem_reg & ~bit_mask) : (mem_reg | bit_mask)))
    else $error("bit write data wrong");
  insn_cycles_a: assert property (
    run_w && cyc_code_reg == cpud_pkg::cyc_n && cls_reg != cpud_pkg::k_rst
    && cls_reg != cpud_pkg::k_irq |-> a_cnt_reg == cyc_reg)
    else $error("instruction cycle count wrong");
  halt_quiet_a: assert property (
    halted_reg |-> !bus_rd_reg && !bus_wr_reg)
    else $error("bus cycle while halted");
  illegal_stop_a: assert property (
    illegal_reg |=> illegal_reg && !bus_rd_reg && !bus_wr_reg)
    else $error("illegal opcode executed");

  wake_c: cover property (halted_reg ##1 !halted_reg ##[1:8] cyc_code_reg == cpud_pkg::cyc_v);
  brbit_c: cover property (run_w && cls_reg == cpud_pkg::k_brbit && step_reg == 3'd4);
  store_c: cover property (run_w && cls_reg == cpud_pkg::k_store && bus_wr_reg);
  illegal_c: cover property ($rose(illegal_reg));
endmodule : cpud_seq

// *** cpud_mem.sv ***
// memory model standing on the far side of the cpu bus
`timescale 1ns/1ps
module cpud_mem (
  input  wire logic        clk_sys, // bus clock
  input  wire logic [15:0] addr,    // cycle address
  input  wire logic        rd,      // read cycle
  input  wire logic        wr,      // write cycle
  input  wire logic [7:0]  wdata,   // write data
  output logic      [7:0]  rdata    // read data, answered in the same cycle
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  // idle bus shows the inverse of the last byte so stale data never looks valid
  assign rdata = rd ? mem[addr] : ~last_q;
  always @(posedge clk_sys) begin
    if (wr) mem[addr] <= wdata;
    if (rd) last_q <= mem[addr];
  end
endmodule : cpud_mem

// *** testbench.sv ***
// self-checking bench: load, transfer, store, branch, wait, interrupt, illegal
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic                 clk_sys, rstn, irq_req, bus_rd_reg, bus_wr_reg, halted_reg, illegal_reg;
  logic [7:0]           bus_rdata, bus_wdata_reg;
  logic [15:0]          bus_addr_reg, hx, sp;
  cpud_pkg::cpud_code_t cyc_code_reg;
  logic [23:0]          exp_q[$], exp_w;
  logic [7:0]           prog[9];
  int                   n_mismatch = 0, num_checks = 0, i;
  cpud_seq i_cpud_seq (.clk_sys(clk_sys), .rstn(rstn), .bus_rdata(bus_rdata),
    .irq_req(irq_req), .bus_addr_reg(bus_addr_reg), .bus_rd_reg(bus_rd_reg),
    .bus_wr_reg(bus_wr_reg), .bus_wdata_reg(bus_wdata_reg), .cyc_code_reg(cyc_code_reg),
    .halted_reg(halted_reg), .illegal_reg(illegal_reg));
  cpud_mem i_cpud_mem (.clk_sys(clk_sys), .addr(bus_addr_reg), .rd(bus_rd_reg),
    .wr(bus_wr_reg), .wdata(bus_wdata_reg), .rdata(bus_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // every write the cpu makes must be the oldest one still expected
  always @(posedge clk_sys) begin
    if (bus_wr_reg) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        exp_w = exp_q.pop_front();
        `CHK({bus_addr_reg, bus_wdata_reg}, exp_w)
      end
    end
    if (rstn && halted_reg) `CHK({bus_rd_reg, bus_wr_reg}, 2'b00)
    if (rstn && !halted_reg && !illegal_reg && cyc_code_reg === cpud_pkg::cyc_f)
      `CHK(bus_rd_reg, 1'b1)
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    irq_req = 1'b0;
    void'($urandom(97));
    hx = {4'h1, 12'($urandom())};
    sp = hx - 16'h0001;
    // load pair, move to stack, store direct 80, branch +0, wait
    prog = '{8'h45, hx[15:8], hx[7:0], 8'h94, 8'h35, 8'h80, 8'h20, 8'h00, 8'h8f};
    for (i = 0; i < 9; i++) i_cpud_mem.mem[16'h0100 + i] = prog[i];
    i_cpud_mem.mem[16'hfffe] = 8'h01;
    i_cpud_mem.mem[16'hffff] = 8'h00;
    i_cpud_mem.mem[16'hfff8] = 8'h02;
    i_cpud_mem.mem[16'hfff9] = 8'h00;
    i_cpud_mem.mem[16'h0200] = 8'h42;
    exp_q = '{{16'h0080, hx[15:8]}, {16'h0081, hx[7:0]},
      {sp, 8'h09}, {sp - 16'h1, 8'h01}, {sp - 16'h2, hx[7:0]},
      {sp - 16'h3, 8'h00}, {sp - 16'h4, 8'h60}};
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 200 && halted_reg !== 1'b1; i++) @(posedge clk_sys);
    `CHK(halted_reg, 1'b1)
    repeat (5) @(posedge clk_sys);
    irq_req <= 1'b1;
    for (i = 0; i < 50 && cyc_code_reg !== cpud_pkg::cyc_v; i++) @(posedge clk_sys);
    irq_req <= 1'b0;
    for (i = 0; i < 50 && illegal_reg !== 1'b1; i++) @(posedge clk_sys);
    `CHK(illegal_reg, 1'b1)
    `CHK(exp_q.size() == 0, 1'b1)
    finish_test();
  end
endmodule : testbench
